// ---- logic/sms_pkg.sv ----
// How it works
// (R1) In sleep, watch for wake-up; then restore power and run a reset sequence.
// (R2) This manager and the real-time clock stay clocked; other activity stops.
// (R3) Peripherals are held in reset for the whole of sleep.
// (R4) Writing the sleep code into the mode field starts sleep entry.
// (R5) An interrupt after a software sleep request abandons entry at once.
// (R6) After a software request, wait until the core pipeline is empty.
// (R7) Memory controller drains pending work and ignores display and DMA requests.
// (R8) After draining, SDRAM is put into self-refresh.
// (R9) After self-refresh, pins take the levels held in three sleep pin registers.
// (R10) Then core clock stops, core power drops, regulator enable falls last.
// (R11) Eight cycles after drain done pins latch; four later reset output goes low.
// (R12) With abort enable set, a fault input raises an imprecise data abort.
// (R13) With abort enable clear, a fault enters sleep at the draining step.
// (R14) Fault abort flag reads set when a fault caused the abort.
// (R15) Supply and battery fault flags are not valid before sleep entry.
// (R16) Outside system asserts a fault input at most once before reset output.
// (R17) A fault during the abort handler raises the abort again.
// (R18) After a fault software must not resume; it enters sleep quickly.
// (R19) Software keeps abort enable clear during sequences that must exit first.
// (R20) Software programs pin, wake and option registers before requesting sleep.
// (R21) Software sets the float bits before sleep and clears them after waking.
// (R22) The scratch-pad register keeps its value across sleep.
package sms_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE    = 8'h00;
  localparam logic [7:0] ADDR_PIN0    = 8'h04;
  localparam logic [7:0] ADDR_PIN1    = 8'h08;
  localparam logic [7:0] ADDR_PIN2    = 8'h0c;
  localparam logic [7:0] ADDR_WSRC    = 8'h10;
  localparam logic [7:0] ADDR_WRISE   = 8'h14;
  localparam logic [7:0] ADDR_WFALL   = 8'h18;
  localparam logic [7:0] ADDR_GCFG    = 8'h1c;
  localparam logic [7:0] ADDR_FCTL    = 8'h20;
  localparam logic [7:0] ADDR_STATUS  = 8'h24;
  localparam logic [7:0] ADDR_SCRATCH = 8'h28;
  localparam logic [7:0] ADDR_ABORT   = 8'h2c;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_RUN      = 2'h0;
  localparam logic [1:0]  MODE_SLEEP    = 2'h3;
  localparam int          CFG_OSC_BIT   = 0;
  localparam int          CFG_SFLT_BIT  = 1;
  localparam int          CFG_PFLT_BIT  = 2;
  localparam int          ST_SUPPLY_BIT = 0;
  localparam int          ST_BATT_BIT   = 1;
  localparam int          ST_HOLD_BIT   = 2;
  localparam int          ABORT_BIT     = 5;
  localparam logic [31:0] WAKE_FAULT    = 32'h0000_0003;
  localparam logic [31:0] WAKE_RESET    = 32'h0000_0003;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [7:0]  PIN_LATCH_CYC  = 8'h08;
  localparam logic [7:0]  RST_ASSERT_CYC = 8'h04;
  localparam int          CLK_NS         = 10;
  localparam int          STAB_TIME_NS   = 2000;
  localparam logic [7:0]  STAB_CYC       = 8'((STAB_TIME_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [3:0] {
    st_run, st_pipe, st_drain, st_pin_wait, st_rst_wait,
    st_clk_stop, st_sleep, st_wake_pwr
  } sms_state_t;
endpackage

// ---- logic/sms_sleep_seq.sv ----
`timescale 1ns/100ps
module sms_sleep_seq
  import sms_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core
  input  wire logic        irq_pending,
  input  wire logic        pipeline_empty,
  output logic             imprecise_abort,
  output logic             core_clk_stop,
  output logic             periph_reset,
  // Memory controller
  output logic             mc_drain_req,
  output logic             mc_block_new,
  input  wire logic        mc_selfrefresh_done,
  // Pins
  input  wire logic        supply_fault_n,
  input  wire logic        battery_fault_n,
  input  wire logic [31:0] wake_pins,
  output logic      [95:0] gpio_sleep_level,
  output logic             gpio_sleep_en,
  output logic             static_float_bit,
  output logic             pcmcia_float_bit,
  output logic             osc_powerdown_option,
  output logic             reset_out_n,
  output logic             regulator_enable_out
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0]  flt_s1, flt_s2, flt_prev;
  logic [31:0] wk_s1, wk_s2, wk_prev;
  logic [1:0]  fault_now;
  logic        fault_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_s1   <= 2'h3;
      flt_s2   <= 2'h3;
      flt_prev <= 2'h0;
      wk_s1    <= 32'h0000_0000;
      wk_s2    <= 32'h0000_0000;
      wk_prev  <= 32'h0000_0000;
    end else begin
      flt_s1   <= {battery_fault_n, supply_fault_n};
      flt_s2   <= flt_s1;
      flt_prev <= fault_now;
      wk_s1    <= wake_pins;
      wk_s2    <= wk_s1;
      wk_prev  <= wk_s2;
    end
  end

  assign fault_now  = ~flt_s2;
  // Every new fault edge counts; the outside side keeps to one per entry
  // (R16) single fault edge
  assign fault_edge = |(fault_now & ~flt_prev);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [1:0]  mode;
  logic [31:0] pin0, pin1, pin2, wsrc, wrise, wfall, scratch;
  logic [2:0]  gcfg, status;
  logic        abort_en, abort_flag;
  logic [1:0]  next_mode;
  logic [31:0] next_pin0, next_pin1, next_pin2, next_wsrc, next_wrise, next_wfall;
  logic [31:0] next_scratch, next_prdata;
  logic [2:0]  next_gcfg, next_status;
  logic        next_abort_en, next_abort_flag;
  logic        wr_en, rd_en, sw_req, clr_mode, fault_sleep, raise_abort, pins_held;
  sms_state_t  state;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a[1:0] == 2'h0) && (a <= ADDR_ABORT);
  endfunction

  assign wr_en   = psel & penable & pwrite & addr_hit(paddr);
  assign rd_en   = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit(paddr);
  // (R4) sleep code write
  assign sw_req  = wr_en && (paddr == ADDR_MODE) && (pwdata[1:0] == MODE_SLEEP);

  always_comb begin
    next_mode = mode;
    next_pin0 = pin0;
    next_pin1 = pin1;
    next_pin2 = pin2;
    next_wsrc = wsrc;
    next_wrise = wrise;
    next_wfall = wfall;
    next_gcfg = gcfg;
    next_abort_en = abort_en;
    next_scratch = scratch;
    next_status = status;
    next_abort_flag = abort_flag;
    next_prdata = prdata;
    if (wr_en) begin
      unique case (paddr)
        ADDR_MODE:    next_mode = pwdata[1:0];
        ADDR_PIN0:    next_pin0 = pwdata;
        ADDR_PIN1:    next_pin1 = pwdata;
        ADDR_PIN2:    next_pin2 = pwdata;
        ADDR_WSRC:    next_wsrc = pwdata;
        ADDR_WRISE:   next_wrise = pwdata;
        ADDR_WFALL:   next_wfall = pwdata;
        ADDR_GCFG:    next_gcfg = pwdata[2:0];
        ADDR_FCTL:    next_abort_en = pwdata[0];
        ADDR_SCRATCH: next_scratch = pwdata;
        ADDR_STATUS:  next_status = status & ~pwdata[2:0];
        ADDR_ABORT:   next_abort_flag = abort_flag & ~pwdata[ABORT_BIT];
        default:      next_mode = mode;
      endcase
    end
    if (clr_mode) begin
      next_mode = MODE_RUN;
    end
    // Fault sleep limits wake-up to the two lowest pins
    if (fault_sleep) begin
      next_wsrc  = WAKE_FAULT;
      next_wrise = WAKE_FAULT;
      next_wfall = WAKE_FAULT;
    end
    // Hardware sets win over software clears
    // (R15) fault type flags
    if (fault_edge) begin
      next_status[ST_SUPPLY_BIT] = next_status[ST_SUPPLY_BIT] | fault_now[0];
      next_status[ST_BATT_BIT]   = next_status[ST_BATT_BIT] | fault_now[1];
    end
    if (pins_held) begin
      next_status[ST_HOLD_BIT] = 1'b1;
    end
    // (R14) abort cause flag
    if (raise_abort) begin
      next_abort_flag = 1'b1;
    end
    if (rd_en) begin
      unique case (paddr)
        ADDR_MODE:    next_prdata = {30'h0, mode};
        ADDR_PIN0:    next_prdata = pin0;
        ADDR_PIN1:    next_prdata = pin1;
        ADDR_PIN2:    next_prdata = pin2;
        ADDR_WSRC:    next_prdata = wsrc;
        ADDR_WRISE:   next_prdata = wrise;
        ADDR_WFALL:   next_prdata = wfall;
        ADDR_GCFG:    next_prdata = {29'h0, gcfg};
        ADDR_FCTL:    next_prdata = {31'h0, abort_en};
        ADDR_STATUS:  next_prdata = {29'h0, status};
        ADDR_SCRATCH: next_prdata = scratch;
        ADDR_ABORT:   next_prdata = {26'h0, abort_flag, 5'h0};
        default:      next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Scratch pad sits outside the sleep reset so it survives sleep
  // (R22) scratch retained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_RUN;
      pin0 <= 32'h0000_0000;
      pin1 <= 32'h0000_0000;
      pin2 <= 32'h0000_0000;
      wsrc <= WAKE_RESET;
      wrise <= WAKE_RESET;
      wfall <= WAKE_RESET;
      gcfg <= 3'h0;
      abort_en <= 1'b0;
      scratch <= 32'h0000_0000;
      status <= 3'h0;
      abort_flag <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      mode <= next_mode;
      pin0 <= next_pin0;
      pin1 <= next_pin1;
      pin2 <= next_pin2;
      wsrc <= next_wsrc;
      wrise <= next_wrise;
      wfall <= next_wfall;
      gcfg <= next_gcfg;
      abort_en <= next_abort_en;
      scratch <= next_scratch;
      status <= next_status;
      abort_flag <= next_abort_flag;
      prdata <= next_prdata;
    end
  end

  assign osc_powerdown_option = gcfg[CFG_OSC_BIT];
  assign static_float_bit     = gcfg[CFG_SFLT_BIT];
  assign pcmcia_float_bit     = gcfg[CFG_PFLT_BIT];

  // ----------------------------------------------------------------
  // Sleep sequencer
  // ----------------------------------------------------------------
  logic [7:0]  cnt, next_cnt;
  logic        sw_entry, next_sw_entry;
  logic [95:0] next_level;
  logic        next_gpio_en, next_abort, wake_hit;
  sms_state_t  next_state;

  // (R1) enabled edge wake-up
  assign wake_hit = |(wsrc & ((wrise & wk_s2 & ~wk_prev) | (wfall & ~wk_s2 & wk_prev)));

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sw_entry = sw_entry;
    next_level = gpio_sleep_level;
    next_gpio_en = gpio_sleep_en;
    next_abort = 1'b0;
    clr_mode = 1'b0;
    fault_sleep = 1'b0;
    raise_abort = 1'b0;
    pins_held = 1'b0;
    // Software releases the pins once it has restored the GPIO block
    if (state == st_run && wr_en && paddr == ADDR_STATUS && pwdata[ST_HOLD_BIT]) begin
      next_gpio_en = 1'b0;
    end
    if (fault_edge && (state inside {st_run, st_pipe}) && abort_en) begin
      // (R12) abort on fault
      // (R17) handler re-entered
      next_abort = 1'b1;
      raise_abort = 1'b1;
    end else if (fault_edge && (state inside {st_run, st_pipe, st_drain}) && !abort_en) begin
      // (R13) skip to drain
      next_state = st_drain;
      next_sw_entry = 1'b0;
      fault_sleep = 1'b1;
    end else begin
      unique case (state)
        st_run: begin
          if (sw_req) begin
            next_state = st_pipe;
            next_sw_entry = 1'b1;
          end
        end
        st_pipe: begin
          // (R5) interrupt abandons
          if (irq_pending) begin
            next_state = st_run;
            clr_mode = 1'b1;
          // (R6) pipeline empty
          end else if (pipeline_empty) begin
            next_state = st_drain;
          end
        end
        st_drain: begin
          if (sw_entry && irq_pending) begin
            next_state = st_run;
            clr_mode = 1'b1;
          // (R8) self-refresh reached
          end else if (mc_selfrefresh_done) begin
            next_state = st_pin_wait;
            next_cnt = 8'h00;
          end
        end
        st_pin_wait: begin
          // (R11) eight cycle wait
          // (R9) latch sleep levels
          if (cnt == PIN_LATCH_CYC - 8'h01) begin
            next_state = st_rst_wait;
            next_cnt = 8'h00;
            next_level = {pin2, pin1, pin0};
            next_gpio_en = 1'b1;
            pins_held = 1'b1;
          end else begin
            next_cnt = cnt + 8'h01;
          end
        end
        st_rst_wait: begin
          // (R11) four more cycles
          if (cnt == RST_ASSERT_CYC - 8'h01) begin
            next_state = st_clk_stop;
          end else begin
            next_cnt = cnt + 8'h01;
          end
        end
        st_clk_stop: next_state = st_sleep;
        st_sleep: begin
          // A low battery keeps the part asleep whatever wakes it
          if (wake_hit && !fault_now[1]) begin
            next_state = st_wake_pwr;
            next_cnt = 8'h00;
          end
        end
        st_wake_pwr: begin
          // (R1) power then reset release
          if (cnt == STAB_CYC - 8'h01) begin
            next_state = st_run;
            clr_mode = 1'b1;
          end else begin
            next_cnt = cnt + 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_run;
      cnt <= 8'h00;
      sw_entry <= 1'b0;
      gpio_sleep_level <= 96'h0;
      gpio_sleep_en <= 1'b0;
      imprecise_abort <= 1'b0;
      mc_drain_req <= 1'b0;
      mc_block_new <= 1'b0;
      reset_out_n <= 1'b1;
      periph_reset <= 1'b0;
      core_clk_stop <= 1'b0;
      regulator_enable_out <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sw_entry <= next_sw_entry;
      gpio_sleep_level <= next_level;
      gpio_sleep_en <= next_gpio_en;
      imprecise_abort <= next_abort;
      // (R7) drain, block display and DMA
      mc_drain_req <= next_state inside {st_drain, st_pin_wait, st_rst_wait};
      mc_block_new <= next_state inside {st_drain, st_pin_wait, st_rst_wait};
      // (R3) peripherals held in reset
      reset_out_n <= !(next_state inside {st_clk_stop, st_sleep, st_wake_pwr});
      periph_reset <= next_state inside {st_clk_stop, st_sleep, st_wake_pwr};
      // (R2) core clock stops; this logic keeps running
      // (R10) clock stop, regulator last
      core_clk_stop <= next_state inside {st_clk_stop, st_sleep, st_wake_pwr};
      regulator_enable_out <= next_state != st_sleep;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  pin_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (state == st_drain && mc_selfrefresh_done && !fault_edge && !(sw_entry && irq_pending))
    |=> !gpio_sleep_en [*8] ##1 gpio_sleep_en)
    else $error("pins not latched eight cycles after drain done");
  reset_delay_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
    $rose(gpio_sleep_en) |-> reset_out_n [*4] ##1 !reset_out_n)
    else $error("reset output not low four cycles after pin latch");
  regulator_last_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
    $fell(regulator_enable_out) |-> $past(core_clk_stop) && !reset_out_n)
    else $error("regulator dropped before clock stop");
  irq_abort_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (state inside {st_pipe, st_drain} && sw_entry && irq_pending && !fault_edge)
    |=> state == st_run && mode == MODE_RUN)
    else $error("interrupt did not abandon sleep entry");
  pipe_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (state == st_pipe && !pipeline_empty && !fault_edge) |=> state != st_drain)
    else $error("drain began with pipeline busy");
  fault_abort_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (fault_edge && abort_en && state == st_run) |=> imprecise_abort && abort_flag)
    else $error("fault did not raise abort");
  fault_skip_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (fault_edge && !abort_en && state == st_run) |=> state == st_drain && mc_drain_req)
    else $error("fault did not jump to drain");
  sleep_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (state == st_sleep) |-> periph_reset && !regulator_enable_out && core_clk_stop)
    else $error("sleep outputs wrong");
  scratch_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // R22
    (state == st_sleep && !wr_en) |=> $stable(scratch))
    else $error("scratch changed in sleep");
  sw_start_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (state == st_run && sw_req && !fault_edge) |=> state == st_pipe)
    else $error("sleep write did not start entry");

  sw_sleep_c: cover property (@(posedge pclk) disable iff (!presetn)
    state == st_pipe ##[1:50] state == st_sleep);
  wake_c: cover property (@(posedge pclk) disable iff (!presetn)
    state == st_wake_pwr ##[1:300] state == st_run);
  fault_c: cover property (@(posedge pclk) disable iff (!presetn)
    fault_edge && abort_en ##1 imprecise_abort);
endmodule

// ---- testbench/sms_far_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Memory controller answer and supply fault detectors
// ----------------------------------------------------------------
module sms_far_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Device side
  input  wire logic       mc_drain_req,
  input  wire logic       reset_out_n,
  // Bench control: fault_go bit0 supply, bit1 battery
  input  wire logic [1:0] fault_go,
  input  wire logic [7:0] mc_lat,
  // Far side answers
  output logic            supply_fault_n,
  output logic            battery_fault_n,
  output logic            mc_selfrefresh_done
);
  logic [7:0] wait_cnt;
  logic       fault_used;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt            <= 8'h00;
      mc_selfrefresh_done <= 1'b0;
      fault_used          <= 1'b0;
      supply_fault_n      <= 1'b1;
      battery_fault_n     <= 1'b1;
    end else begin
      // Latency is chosen per scenario so prompt and slow answers both occur
      if (!mc_drain_req) begin
        wait_cnt            <= 8'h00;
        mc_selfrefresh_done <= 1'b0;
      end else if (wait_cnt >= mc_lat) begin
        mc_selfrefresh_done <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 8'h01;
      end
      // one fault shot per reset output
      if (!reset_out_n) begin
        fault_used      <= 1'b0;
        supply_fault_n  <= 1'b1;
        battery_fault_n <= 1'b1;
      end else if (fault_go != 2'b00 && !fault_used) begin
        fault_used      <= 1'b1;
        supply_fault_n  <= !fault_go[0];
        battery_fault_n <= !fault_go[1];
      end
    end
  end
endmodule

// ---- testbench/test_sleep_mode_entry_sequencer.sv ----
`timescale 1ns/100ps
module test_sleep_mode_entry_sequencer;
  import sms_pkg::*;
  localparam logic [31:0] P0 = 32'h1111_0001;
  localparam logic [31:0] P1 = 32'h2222_0002;
  localparam logic [31:0] P2 = 32'h4444_0004;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, mc_lat;
  logic [31:0] pwdata, prdata, wake_pins;
  logic        irq_pending, pipeline_empty, imprecise_abort, core_clk_stop, periph_reset;
  logic        mc_drain_req, mc_block_new, mc_selfrefresh_done, supply_fault_n;
  logic        battery_fault_n, gpio_sleep_en, static_float_bit, pcmcia_float_bit;
  logic        osc_powerdown_option, reset_out_n, regulator_enable_out;
  logic [95:0] gpio_sleep_level;
  logic [1:0]  fault_go;
  int          n_fail, n_checks;

  sms_sleep_seq dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_pending(irq_pending), .pipeline_empty(pipeline_empty),
    .imprecise_abort(imprecise_abort), .core_clk_stop(core_clk_stop),
    .periph_reset(periph_reset), .mc_drain_req(mc_drain_req), .mc_block_new(mc_block_new),
    .mc_selfrefresh_done(mc_selfrefresh_done), .supply_fault_n(supply_fault_n),
    .battery_fault_n(battery_fault_n), .wake_pins(wake_pins),
    .gpio_sleep_level(gpio_sleep_level), .gpio_sleep_en(gpio_sleep_en),
    .static_float_bit(static_float_bit), .pcmcia_float_bit(pcmcia_float_bit),
    .osc_powerdown_option(osc_powerdown_option), .reset_out_n(reset_out_n),
    .regulator_enable_out(regulator_enable_out));

  sms_far_model far_u (
    .pclk(pclk), .presetn(presetn), .mc_drain_req(mc_drain_req), .reset_out_n(reset_out_n),
    .fault_go(fault_go), .mc_lat(mc_lat), .supply_fault_n(supply_fault_n),
    .battery_fault_n(battery_fault_n), .mc_selfrefresh_done(mc_selfrefresh_done));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [95:0] seen, input logic [95:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, 96'(r), 96'(exp));
    chk({what, " err"}, 96'(e), 96'(exp_err));
  endtask

  task automatic set_pins();
    wr(ADDR_PIN0, P0);
    wr(ADDR_PIN1, P1);
    wr(ADDR_PIN2, P2);
  endtask

  // Timeline counted from the edge where self-refresh done is first sampled
  task automatic sleep_tail();
    int n;
    for (n = 0; n < 100 && mc_selfrefresh_done !== 1'b1; n++) @(posedge pclk);
    chk("display and dma blocked", 96'(mc_block_new), 96'h1);
    for (n = 1; n <= 14; n++) begin
      @(posedge pclk);
      if (n == 8 || n == 9) chk("pins switched", 96'(gpio_sleep_en), 96'(n == 9));
      if (n == 9) chk("pin levels", gpio_sleep_level, {P2, P1, P0});
      if (n == 12 || n == 13) chk("reset out", 96'(reset_out_n), 96'(n == 12));
      if (n == 13) chk("periph reset", 96'(periph_reset), 96'h1);
      if (n == 13) chk("core clock stop", 96'(core_clk_stop), 96'h1);
      if (n == 13 || n == 14) chk("regulator", 96'(regulator_enable_out), 96'(n == 13));
    end
  endtask

  task automatic wake_up();
    int n;
    wake_pins[0] <= ~wake_pins[0];
    for (n = 0; n < 20 && regulator_enable_out !== 1'b1; n++) @(posedge pclk);
    chk("power restored", 96'(regulator_enable_out), 96'h1);
    for (n = 0; n < 400 && reset_out_n !== 1'b1; n++) @(posedge pclk);
    chk("reset sequence length", 96'(n >= STAB_CYC && n <= STAB_CYC + 3), 96'h1);
    chk("periph reset dropped", 96'(periph_reset), 96'h0);
    rd_chk("mode cleared", ADDR_MODE, 32'h0, 1'b0);
    wr(ADDR_STATUS, 32'h4);
  endtask

  task automatic wait_drain();
    int n;
    for (n = 0; n < 30 && mc_drain_req !== 1'b1; n++) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    chk("reset out idle", 96'(reset_out_n), 96'h1);
    rd_chk("wake source", ADDR_WSRC, WAKE_RESET, 1'b0);
    rd_chk("wake fall", ADDR_WFALL, WAKE_RESET, 1'b0);
    rd_chk("unmapped", 8'h30, 32'h0, 1'b1);
    wr(ADDR_GCFG, 32'h5);
    // Config outputs settle only after the write edge
    @(posedge pclk);
    chk("osc option", 96'(osc_powerdown_option), 96'h1);
    chk("float bits", 96'({static_float_bit, pcmcia_float_bit}), 96'h1);
  endtask

  task automatic t_sw_sleep();
    set_pins();
    wr(ADDR_SCRATCH, 32'h5a5a_c3c3);
    pipeline_empty <= 1'b0;
    mc_lat         <= 8'h14;
    wr(ADDR_MODE, {30'h0, MODE_SLEEP});
    repeat (10) @(posedge pclk);
    chk("drain waits pipeline", 96'(mc_drain_req), 96'h0);
    pipeline_empty <= 1'b1;
    wait_drain();
    chk("drain started", 96'(mc_drain_req), 96'h1);
    sleep_tail();
    wake_up();
    rd_chk("scratch kept", ADDR_SCRATCH, 32'h5a5a_c3c3, 1'b0);
  endtask

  task automatic t_irq();
    pipeline_empty <= 1'b0;
    wr(ADDR_MODE, {30'h0, MODE_SLEEP});
    irq_pending <= 1'b1;
    repeat (3) @(posedge pclk);
    pipeline_empty <= 1'b1;
    irq_pending    <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("entry abandoned", 96'(mc_drain_req), 96'h0);
    rd_chk("mode back to run", ADDR_MODE, {30'h0, MODE_RUN}, 1'b0);
  endtask

  task automatic t_fault_abort();
    int n;
    logic seen;
    wr(ADDR_FCTL, 32'h1);
    fault_go <= 2'b01;
    seen = 1'b0;
    for (n = 0; n < 10; n++) begin
      @(posedge pclk);
      fault_go <= 2'b00;
      seen |= imprecise_abort;
    end
    chk("abort raised", 96'(seen), 96'h1);
    chk("no sleep on its own", 96'(mc_drain_req), 96'h0);
    rd_chk("abort flag set", ADDR_ABORT, 32'h20, 1'b0);
    set_pins();
    mc_lat <= 8'h00;
    wr(ADDR_MODE, {30'h0, MODE_SLEEP});
    wait_drain();
    sleep_tail();
    wake_up();
    wr(ADDR_ABORT, 32'h20);
    wr(ADDR_STATUS, 32'h3);
    rd_chk("abort flag clear", ADDR_ABORT, 32'h0, 1'b0);
  endtask

  task automatic t_fault_direct();
    int n;
    logic seen;
    wr(ADDR_FCTL, 32'h0);
    set_pins();
    pipeline_empty <= 1'b0;
    fault_go       <= 2'b10;
    seen = 1'b0;
    for (n = 0; n < 10 && mc_drain_req !== 1'b1; n++) begin
      @(posedge pclk);
      fault_go <= 2'b00;
      seen |= imprecise_abort;
    end
    chk("fault drains at once", 96'(mc_drain_req), 96'h1);
    chk("no abort", 96'(seen), 96'h0);
    pipeline_empty <= 1'b1;
    sleep_tail();
    wake_up();
    rd_chk("battery fault status", ADDR_STATUS, 32'h2, 1'b0);
  endtask

  task automatic summarize();
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, irq_pending, pipeline_empty, presetn} = 6'h00;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    wake_pins = 32'h0;
    fault_go  = 2'b00;
    mc_lat    = 8'h00;
    n_fail    = 0;
    n_checks  = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sw_sleep();
    t_irq();
    t_fault_abort();
    t_fault_direct();
    summarize();
  end

  // Whole run needs under a thousand cycles
  initial begin
    #(40000 * 10);
    n_fail++;
    summarize();
  end
endmodule
